// *** common/irq_pkg.sv ***
// package: constants, register map and types for the vectored irq controller
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package irq_pkg;
  localparam int NUM_IRQ = 35;
  localparam int ID_W    = 6;
  localparam int PRIO_W  = 4;
  localparam logic [11:0] ENABLE_SET_OFS   = 12'h000;
  localparam logic [11:0] ENABLE_CLR_OFS   = 12'h008;
  localparam logic [11:0] PEND_SET_OFS     = 12'h010;
  localparam logic [11:0] PEND_CLR_OFS     = 12'h018;
  localparam logic [11:0] ACTIVE_OFS       = 12'h020;
  localparam logic [11:0] PRIO_OFS         = 12'h040;
  localparam logic [11:0] PRIO_END_OFS     = 12'h060;
  localparam logic [11:0] TRIGGER_OFS      = 12'h080;
  localparam logic [11:0] GROUP_SPLIT_OFS  = 12'h084;
  localparam logic [11:0] OFFER_OFS        = 12'h088;
  localparam logic [2:0]  GROUP_SPLIT_RST  = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_RST   = 4'h0;
  localparam logic [ID_W-1:0] NMI_ID       = 6'h3f;
  localparam logic [ID_W-1:0] NONE_ID      = 6'h3e;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_PEND   = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_BOTH   = 2'b11
  } irq_state_t;
endpackage

// *** common/arb_if.sv ***
// interface: arbiter request and result bundle
`timescale 1ns/1ps
`default_nettype none
interface arb_if;
  import irq_pkg::*;
  logic [NUM_IRQ-1:0]        req;
  logic [NUM_IRQ*PRIO_W-1:0] prio;
  logic [2:0]                split;
  logic                      found;
  logic [ID_W-1:0]           id;
  logic [PRIO_W-1:0]         group;
  modport master (output req, output prio, output split, input found, input id, input group);
  modport arb    (input req, input prio, input split, output found, output id, output group);
endinterface
`default_nettype wire

// *** core/irq_arbiter.sv ***
// module: picks the most urgent pending and enabled interrupt
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter
  import irq_pkg::*;
(
  arb_if.arb a
);
  logic              f_c [NUM_IRQ+1];
  logic [ID_W-1:0]   i_c [NUM_IRQ+1];
  logic [PRIO_W-1:0] p_c [NUM_IRQ+1];
  logic [PRIO_W-1:0] gmask;

  // group part keeps the bits above the split point
  assign gmask = 4'hf << a.split;
  assign f_c[0] = 1'b0;
  assign i_c[0] = NONE_ID;
  assign p_c[0] = 4'hf;
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++) begin : g_chain
      logic [PRIO_W-1:0] pv;
      logic              take;
      assign pv = a.prio[g*PRIO_W +: PRIO_W];
      // strict less keeps ties on the lower number
      assign take = a.req[g] && (!f_c[g] || pv < p_c[g]);
      assign f_c[g+1] = f_c[g] | a.req[g];
      assign i_c[g+1] = take ? ID_W'(g) : i_c[g];
      assign p_c[g+1] = take ? pv : p_c[g];
    end
  endgenerate
  assign a.found = f_c[NUM_IRQ];
  assign a.id    = i_c[NUM_IRQ];
  assign a.group = p_c[NUM_IRQ] & gmask;
endmodule
`default_nettype wire

// *** core/vectored_irq_controller.sv ***
// module: pending/active tracking, apb registers and offer to the core
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module vectored_irq_controller
  import irq_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NUM_IRQ-1:0] irq_line,
  input  wire logic               nmi_line,
  input  wire logic               enter,
  input  wire logic [ID_W-1:0]    enter_id,
  input  wire logic               leave,
  input  wire logic [ID_W-1:0]    leave_id,
  output logic                    offer_valid,
  output logic [ID_W-1:0]         offer_id,
  output logic [PRIO_W-1:0]       offer_group
);
  // ---------------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------------
  logic [NUM_IRQ:0] s1_reg, s2_reg, s3_reg;
  logic [NUM_IRQ-1:0] lvl, rise;
  logic nmi_lvl, nmi_rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= {nmi_line, irq_line};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // a level is taken once the second and third stages agree
  logic [NUM_IRQ:0] st_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_reg <= '0;
    else st_reg <= (s2_reg & s3_reg) | (st_reg & (s2_reg | s3_reg));
  end
  logic [NUM_IRQ:0] stp_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stp_reg <= '0;
    else stp_reg <= st_reg;
  end
  assign lvl      = st_reg[NUM_IRQ-1:0];
  assign rise     = st_reg[NUM_IRQ-1:0] & ~stp_reg[NUM_IRQ-1:0];
  assign nmi_lvl  = st_reg[NUM_IRQ];
  assign nmi_rise = st_reg[NUM_IRQ] & ~stp_reg[NUM_IRQ];

  // ---------------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------------
  function automatic logic [NUM_IRQ-1:0] bank_bits(input logic [11:0] a,
                                                   input logic [11:0] base,
                                                   input logic [31:0] d);
    logic [63:0] w;
    w = 64'h0;
    if (a == base) w[31:0] = d;
    if (a == base + 12'h004) w[63:32] = d;
    bank_bits = w[NUM_IRQ-1:0];
  endfunction

  logic wr, rd;
  // a write lands only at the edge that sees the answer, and never on a refused address
  assign wr = psel && penable && pwrite && pready && mapped;
  assign rd = psel && !pwrite;
  logic [NUM_IRQ-1:0] en_set_w, en_clr_w, pd_set_w, pd_clr_w, trig_w;
  assign en_set_w = wr ? bank_bits(paddr, ENABLE_SET_OFS, pwdata) : '0;
  assign en_clr_w = wr ? bank_bits(paddr, ENABLE_CLR_OFS, pwdata) : '0;
  assign pd_set_w = wr ? bank_bits(paddr, PEND_SET_OFS, pwdata) : '0;
  assign pd_clr_w = wr ? bank_bits(paddr, PEND_CLR_OFS, pwdata) : '0;
  logic trig_hit;
  assign trig_hit = wr && paddr == TRIGGER_OFS && pwdata[8:0] < 9'(NUM_IRQ);
  generate
    for (genvar t = 0; t < NUM_IRQ; t++) begin : g_trig
      assign trig_w[t] = trig_hit && pwdata[8:0] == 9'(t);
    end
  endgenerate
  logic prio_hit, split_hit, mapped;
  assign prio_hit  = paddr >= PRIO_OFS && paddr < PRIO_END_OFS;
  assign split_hit = paddr == GROUP_SPLIT_OFS;
  assign mapped = paddr[1:0] == 2'b00 && (prio_hit || split_hit || paddr == TRIGGER_OFS
                  || paddr == OFFER_OFS || paddr < ACTIVE_OFS + 12'h008);

  // ---------------------------------------------------------------------------
  // enable, priority, split
  // ---------------------------------------------------------------------------
  logic [NUM_IRQ-1:0]        en_reg;
  logic [NUM_IRQ*PRIO_W-1:0] prio_reg;
  logic [2:0]                split_reg;
  logic [3:0]                prio_word;
  assign prio_word = paddr[5:2] - PRIO_OFS[5:2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg    <= '0;
      prio_reg  <= {NUM_IRQ{PRIO_RST}};
      split_reg <= GROUP_SPLIT_RST;
    end else begin
      en_reg <= (en_reg | en_set_w) & ~en_clr_w;
      if (wr && split_hit) split_reg <= pwdata[2:0];
      if (wr && prio_hit) begin
        for (int k = 0; k < 8; k++) begin
          if (int'(prio_word) * 8 + k < NUM_IRQ)
            prio_reg[(int'(prio_word) * 8 + k) * PRIO_W +: PRIO_W]
              <= pwdata[k*4 +: 4];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // per-interrupt state
  // ---------------------------------------------------------------------------
  logic [NUM_IRQ-1:0] pend_reg, act_reg, pend_next, act_next;
  generate
    for (genvar i = 0; i < NUM_IRQ; i++) begin : g_state
      logic ent, lev, setp;
      assign ent = enter && enter_id == ID_W'(i);
      assign lev = leave && leave_id == ID_W'(i);
      // sources that set pending; set wins over any clear
      assign setp = (lvl[i] && !act_reg[i] && !ent)
                  || rise[i]
                  || pd_set_w[i] || trig_w[i]
                  || (lev && lvl[i]);
      always_comb begin
        pend_next[i] = pend_reg[i];
        act_next[i]  = act_reg[i];
        if (ent && pend_reg[i]) begin
          pend_next[i] = 1'b0;
          act_next[i]  = 1'b1;
        end
        if (lev) act_next[i] = 1'b0;
        if (pd_clr_w[i] && !lvl[i]) pend_next[i] = 1'b0;
        if (setp) pend_next[i] = 1'b1;
      end
    end
  endgenerate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= '0;
      act_reg  <= '0;
    end else begin
      pend_reg <= pend_next;
      act_reg  <= act_next;
    end
  end

  // nmi: pending on edge or on level while not active, active while serviced
  logic nmi_pend_reg, nmi_act_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_pend_reg <= 1'b0;
      nmi_act_reg  <= 1'b0;
    end else begin
      if (enter && enter_id == NMI_ID) begin
        nmi_pend_reg <= 1'b0;
        nmi_act_reg  <= 1'b1;
      end
      if (leave && leave_id == NMI_ID) nmi_act_reg <= 1'b0;
      if (nmi_rise || (nmi_lvl && !nmi_act_reg && !(enter && enter_id == NMI_ID)))
        nmi_pend_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // arbitration and offer
  // ---------------------------------------------------------------------------
  arb_if arb_bus ();
  assign arb_bus.req   = pend_reg & en_reg & ~act_reg;
  assign arb_bus.prio  = prio_reg;
  assign arb_bus.split = split_reg;
  irq_arbiter u_arb (
    .a (arb_bus)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offer_valid <= 1'b0;
      offer_id    <= NONE_ID;
      offer_group <= '0;
    end else if (nmi_pend_reg) begin
      offer_valid <= 1'b1;
      offer_id    <= NMI_ID;
      offer_group <= '0;
    end else begin
      offer_valid <= arb_bus.found;
      offer_id    <= arb_bus.id;
      offer_group <= arb_bus.found ? arb_bus.group : '0;
    end
  end

  // ---------------------------------------------------------------------------
  // apb read and answer
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] bank_rd(input logic [11:0] a, input logic [11:0] base,
                                          input logic [NUM_IRQ-1:0] v);
    logic [63:0] w;
    w = 64'(v);
    bank_rd = (a == base) ? w[31:0] : (a == base + 12'h004) ? w[63:32] : 32'h0;
  endfunction
  logic [31:0] prio_rd, rd_mux;
  always_comb begin
    prio_rd = 32'h0;
    for (int k = 0; k < 8; k++) begin
      if (int'(prio_word) * 8 + k < NUM_IRQ)
        prio_rd[k*4 +: 4] = prio_reg[(int'(prio_word) * 8 + k) * PRIO_W +: PRIO_W];
    end
  end
  assign rd_mux = bank_rd(paddr, ENABLE_SET_OFS, en_reg) | bank_rd(paddr, ENABLE_CLR_OFS, en_reg)
                | bank_rd(paddr, PEND_SET_OFS, pend_reg) | bank_rd(paddr, PEND_CLR_OFS, pend_reg)
                | bank_rd(paddr, ACTIVE_OFS, act_reg)
                | (prio_hit ? prio_rd : 32'h0)
                | (split_hit ? {29'h0, split_reg} : 32'h0)
                | (paddr == OFFER_OFS ? {16'h0, 3'h0, offer_valid, offer_group,
                                         2'h0, offer_id} : 32'h0);
  // one wait state: answer in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata  <= (rd && penable && !pready && mapped) ? rd_mux : 32'h0;
    end
  end
endmodule
`default_nettype wire

// *** testbench/irq_checker_props.sv ***
// checker: port-level properties of the vectored irq controller
`timescale 1ns/1ps
`default_nettype none
module irq_checker
  import irq_pkg::*;
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            nmi_line,
  input wire logic            enter,
  input wire logic [ID_W-1:0] enter_id,
  input wire logic            offer_valid,
  input wire logic [ID_W-1:0] offer_id
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_enter_winner;
    enter && offer_valid && enter_id == offer_id && enter_id != NMI_ID;
  endsequence
  a_ready_follows: assert property (s_access |=> pready)
    else $error("pready missing after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_quiet_data: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside answer");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("data with error answer");
  a_err_unaligned: assert property ((s_access and paddr[1:0] != 2'h0) |=> pslverr)
    else $error("unaligned access not refused");
  a_nmi_offered: assert property ((nmi_line && !enter)[*8] |-> offer_id == NMI_ID)
    else $error("nmi not offered");
  a_idle_none: assert property (!offer_valid |-> offer_id == NONE_ID)
    else $error("idle offer id wrong");
  a_enter_hides: assert property (s_enter_winner |-> ##2 offer_id != $past(offer_id, 2))
    else $error("entered irq still offered");
endmodule
bind vectored_irq_controller irq_checker irq_checker_i (.pclk, .presetn, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .nmi_line, .enter, .enter_id, .offer_valid, .offer_id);
`default_nettype wire

// *** testbench/periph_model.sv ***
// partner: peripherals that hold their request lines until satisfied
`timescale 1ns/1ps
`default_nettype none
module periph_model
  import irq_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [NUM_IRQ-1:0] raise,
  input  wire logic [NUM_IRQ-1:0] satisfy,
  output logic      [NUM_IRQ-1:0] irq_line
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_line <= '0;
    else irq_line <= (irq_line | raise) & ~satisfy;
  end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// testbench: apb and core-side sequences with expected values
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import irq_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, nmi_line = 0, enter = 0, leave = 0, offer_valid;
  logic [ID_W-1:0] enter_id = '0, leave_id = '0, offer_id;
  logic [PRIO_W-1:0] offer_group;
  logic [NUM_IRQ-1:0] raise = '0, satisfy = '0, irq_line;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  logic [31:0] r;
  logic e;
  always #20 pclk = ~pclk;
  vectored_irq_controller vectored_irq_controller_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_line, .nmi_line, .enter,
    .enter_id, .leave, .leave_id, .offer_valid, .offer_id, .offer_group);
  periph_model periph_model_i (.pclk, .presetn, .raise, .satisfy, .irq_line);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      complete_run;
    end
  end
  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk($sformatf("reg %h", a), x, r);
  endtask
  task automatic core(input logic lv, input logic [ID_W-1:0] id);
    enter <= !lv; leave <= lv; enter_id <= id; leave_id <= id;
    @(posedge pclk);
    enter <= 0; leave <= 0;
    w(3);
  endtask
  // ----------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------
  initial begin
    w(2);
    presetn <= 1;
    w(1);
    chk("offer_id", NONE_ID, offer_id);
    rd(GROUP_SPLIT_OFS, 32'h0);
    rd(PRIO_OFS, 32'h0);
    $display("test reset done");
    apb(1, PEND_SET_OFS, 32'h8);
    rd(PEND_SET_OFS, 32'h8);
    chk("offer_valid", 1'b0, offer_valid);
    apb(1, ENABLE_SET_OFS, 32'h8);
    apb(1, ENABLE_SET_OFS + 12'h4, 32'h2);
    apb(1, TRIGGER_OFS, 32'd33);
    rd(PEND_SET_OFS + 12'h4, 32'h2);
    w(2);
    chk("offer_id", 6'd3, offer_id);
    apb(1, PRIO_OFS, 32'h0000f000);
    apb(1, PRIO_OFS + 12'h10, 32'h00000070);
    apb(1, GROUP_SPLIT_OFS, 32'h2);
    rd(PRIO_OFS, 32'h0000f000);
    w(2);
    chk("offer_id", 6'd33, offer_id);
    chk("offer_group", 4'h4, offer_group);
    rd(OFFER_OFS, 32'h00001421);
    $display("test priority done");
    core(0, 6'd33);
    rd(ACTIVE_OFS + 12'h4, 32'h2);
    rd(PEND_SET_OFS + 12'h4, 32'h0);
    core(1, 6'd33);
    rd(ACTIVE_OFS + 12'h4, 32'h0);
    apb(1, PEND_CLR_OFS, 32'h8);
    rd(PEND_SET_OFS, 32'h0);
    $display("test service done");
    raise[5] <= 1;
    apb(1, ENABLE_SET_OFS, 32'h20);
    raise[5] <= 0;
    w(8);
    rd(PEND_SET_OFS, 32'h20);
    apb(1, PEND_CLR_OFS, 32'h20);
    rd(PEND_SET_OFS, 32'h20);
    core(0, 6'd5);
    rd(ACTIVE_OFS, 32'h20);
    core(1, 6'd5);
    rd(PEND_SET_OFS, 32'h20);
    satisfy[5] <= 1;
    w(8);
    core(0, 6'd5);
    core(1, 6'd5);
    rd(PEND_SET_OFS, 32'h0);
    rd(ACTIVE_OFS, 32'h0);
    $display("test level done");
    apb(0, 12'h200, 0);
    chk("pslverr", 1'b1, e);
    apb(0, 12'h002, 0);
    chk("pslverr", 1'b1, e);
    apb(1, PRIO_OFS + 12'h2, 32'hffffffff);
    chk("pslverr", 1'b1, e);
    rd(PRIO_OFS, 32'h0000f000);
    nmi_line <= 1;
    w(10);
    chk("offer_id", NMI_ID, offer_id);
    nmi_line <= 0;
    core(0, NMI_ID);
    core(1, NMI_ID);
    w(6);
    chk("offer_valid", 1'b0, offer_valid);
    rd(ENABLE_CLR_OFS, 32'h00000028);
    apb(1, ENABLE_CLR_OFS, 32'h00000028);
    rd(ENABLE_SET_OFS, 32'h0);
    rd(OFFER_OFS, 32'h0000003e);
    $display("test nmi done");
    complete_run;
  end
endmodule
`default_nettype wire
